// ### hdl/wds_sar.sv
`include "wds_map.svh"
`default_nettype none

// successive approximation sequencer, one step per clock tick
module wds_sar (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset,
  // timing and comparator
  input  wire logic       tick,
  input  wire logic       comp_high,
  // trial code and result
  output logic [7:0]      dac_code,
  output logic [7:0]      result,
  output logic            done
);

  logic [3:0] step;
  logic [3:0] next_step;
  logic [7:0] mask;
  logic [7:0] next_mask;
  logic [7:0] next_dac_code;
  logic [7:0] next_result;
  logic       next_done;

  // ---------------------------------------------------------------
  // conversion sequence
  // ---------------------------------------------------------------
  // step 0 loads the midscale trial, steps 1..8 each settle one bit
  always_comb begin
    next_step     = step;
    next_mask     = mask;
    next_dac_code = dac_code;
    next_result   = result;
    next_done     = 1'b0;
    if (tick) begin
      if (step == 4'h0) begin
        next_dac_code = 8'h80;
        next_mask     = 8'h80;
        next_step     = 4'h1;
      end else begin
        next_dac_code = comp_high ? dac_code : (dac_code & ~mask);
        next_mask     = mask >> 1;
        next_dac_code = next_dac_code | next_mask;
        if (step == 4'(`WDS_SAR_STEPS)) begin
          next_result = comp_high ? dac_code : (dac_code & ~mask);
          next_done   = 1'b1;
          next_step   = 4'h0;
        end else begin
          next_step = step + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      step     <= 4'h0;
      mask     <= 8'h00;
      dac_code <= 8'h00;
      result   <= 8'h00;
      done     <= 1'b0;
    end else begin
      step     <= next_step;
      mask     <= next_mask;
      dac_code <= next_dac_code;
      result   <= next_result;
      done     <= next_done;
    end
  end

endmodule : wds_sar

`default_nettype wire

// ### hdl/wds_top.sv
`include "wds_map.svh"
`default_nettype none

module wds_top #(
  parameter int unsigned DEPTH        = `WDS_TABLE_DEPTH,
  parameter int unsigned MARKER_TICKS = `WDS_MARKER_TICKS
) (
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 reset,
  // instrument bus
  input  wire wds_pkg::wds_bus_req_s bus_req,
  output logic [7:0]                bus_rdata,
  // timing and analog comparator pins
  input  wire logic                 processor_phase_two_clock,
  input  wire logic                 vert_comp_high,
  input  wire logic                 peak_average_select,
  input  wire logic [9:0]           sweep_x_code,
  // conversion
  output logic [7:0]                vert_dac_code,
  output logic                      conversion_done_pulse,
  output logic                      x_change_divide_start,
  // display
  output logic [9:0]                disp_x,
  output logic [7:0]                disp_y,
  output logic                      disp_blank,
  output logic                      cursor_cycle_select,
  output logic                      disp_trace_b,
  output logic                      marker_pause
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [17:0] req_s1, req_s2;
  logic [12:0] pin_s1, pin_s2;
  logic        phi2_q, wr_q, rd_q;
  wds_pkg::wds_bus_req_s req;
  logic        tick, comp_s, pas_s, wr_pulse, rd_pulse;
  logic [9:0]  acq_x;

  // strobes and data are slow next to core_clk, so two flops each suffice
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      req_s1 <= '0;
      req_s2 <= '0;
      pin_s1 <= '0;
      pin_s2 <= '0;
      phi2_q <= 1'b0;
      wr_q   <= 1'b0;
      rd_q   <= 1'b0;
    end else begin
      req_s1 <= bus_req;
      req_s2 <= req_s1;
      pin_s1 <= {processor_phase_two_clock, vert_comp_high, peak_average_select, sweep_x_code};
      pin_s2 <= pin_s1;
      phi2_q <= pin_s2[12];
      wr_q   <= req_s2[17];
      rd_q   <= req_s2[16];
    end
  end

  assign req      = req_s2;
  assign tick     = pin_s2[12] & ~phi2_q;
  assign comp_s   = pin_s2[11];
  assign pas_s    = pin_s2[10];
  assign acq_x    = pin_s2[9:0];
  assign wr_pulse = req.wr & ~wr_q;
  assign rd_pulse = req.rd & ~rd_q;

  // ---------------------------------------------------------------
  // converter
  // ---------------------------------------------------------------
  logic [7:0] sample;

  wds_sar u_sar (
    .core_clk  (core_clk),
    .reset     (reset),
    .tick      (tick),
    .comp_high (comp_s),
    .dac_code  (vert_dac_code),
    .result    (sample),
    .done      (conversion_done_pulse)
  );

  // ---------------------------------------------------------------
  // storage and address decoding helpers
  // ---------------------------------------------------------------
  // 2 x 500 x 8 bits of flip-flop storage, never reset
  logic [7:0] mem [0:1][0:DEPTH-1];

  // position to table entry; odd positions belong to table B
  function automatic logic [8:0] index_of(input logic [9:0] x);
    index_of = x[9:1];
  endfunction : index_of

  function automatic logic [7:0] mem_rd(input logic tbl, input logic [8:0] idx);
    mem_rd = (32'(idx) < DEPTH) ? mem[tbl][idx] : 8'h00;
  endfunction : mem_rd

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  logic [2:0] subaddr, next_subaddr;
  logic       vert_sel, next_vert_sel;
  logic [4:0] mode, next_mode;
  logic [7:0] diff_k, next_diff_k;
  logic [7:0] cursor_level, next_cursor_level;
  logic [8:0] rd_idx, next_rd_idx;
  logic       rd_tbl, next_rd_tbl;
  logic [7:0] next_bus_rdata;
  logic [7:0] last_sample;
  logic       hold_a, max_on, diff_on, show_a, show_b, acc_busy;

  assign hold_a  = mode[`WDS_MODE_HOLD_A_BIT];
  assign max_on  = mode[`WDS_MODE_MAX_BIT];
  assign diff_on = mode[`WDS_MODE_DIFF_BIT];
  assign show_a  = mode[`WDS_MODE_SHOW_A_BIT];
  assign show_b  = mode[`WDS_MODE_SHOW_B_BIT];

  // write decode, then read answer; the section bit picks the responder
  always_comb begin
    next_subaddr      = subaddr;
    next_vert_sel     = vert_sel;
    next_mode         = mode;
    next_diff_k       = diff_k;
    next_cursor_level = cursor_level;
    next_rd_idx       = rd_idx;
    next_rd_tbl       = rd_tbl;
    next_bus_rdata    = bus_rdata;
    if (wr_pulse && req.addr == `WDS_ADDR_WR_B) begin
      next_subaddr  = req.wdata[`WDS_SUB_MSB:`WDS_SUB_LSB];
      next_vert_sel = req.wdata[`WDS_SECT_BIT];
    end else if (wr_pulse && req.addr == `WDS_ADDR_WR_A) begin
      if (vert_sel) begin
        next_diff_k = req.wdata;
      end else begin
        unique case (subaddr)
          `WDS_SUB_MODE:   next_mode         = req.wdata[4:0];
          `WDS_SUB_CURSOR: next_cursor_level = req.wdata;
          `WDS_SUB_RD_LO:  next_rd_idx[7:0]  = req.wdata;
          `WDS_SUB_RD_HI: begin
            next_rd_idx[8] = req.wdata[0];
            next_rd_tbl    = req.wdata[`WDS_RD_TBL_BIT];
          end
          default: ;  // remaining subaddresses are ignored
        endcase
      end
    end
    if (rd_pulse) begin
      if (req.addr == `WDS_ADDR_RD_A) begin
        next_bus_rdata = vert_sel ? mem_rd(rd_tbl, rd_idx) : acq_x[7:0];
      end else if (req.addr == `WDS_ADDR_RD_B) begin
        next_bus_rdata = vert_sel ? last_sample : {acc_busy, mode, acq_x[9:8]};
      end else begin
        next_bus_rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      subaddr      <= 3'h0;
      vert_sel     <= 1'b0;
      mode         <= `WDS_MODE_RESET;
      diff_k       <= 8'h00;
      cursor_level <= 8'h00;
      rd_idx       <= 9'h000;
      rd_tbl       <= 1'b0;
      bus_rdata    <= 8'h00;
    end else begin
      subaddr      <= next_subaddr;
      vert_sel     <= next_vert_sel;
      mode         <= next_mode;
      diff_k       <= next_diff_k;
      cursor_level <= next_cursor_level;
      rd_idx       <= next_rd_idx;
      rd_tbl       <= next_rd_tbl;
      bus_rdata    <= next_bus_rdata;
    end
  end

  // ---------------------------------------------------------------
  // accumulation, division and table update
  // ---------------------------------------------------------------
  wds_pkg::wds_acc_e         acc_st, next_acc_st;
  logic [`WDS_SUM_W-1:0]     sum, next_sum, num, next_num;
  logic [`WDS_CNT_W-1:0]     cnt, next_cnt, den, next_den;
  logic [7:0]                peak, next_peak, cl_peak, next_cl_peak;
  logic [7:0]                quot, next_quot, next_last_sample;
  logic [9:0]                cur_x, next_cur_x, cl_x, next_cl_x;
  logic                      cur_valid, next_cur_valid, cl_pas, next_cl_pas;
  logic [2:0]                bit_k, next_bit_k;
  logic                      next_start;
  logic [`WDS_SUM_W-1:0]     trial;
  logic [7:0]                wval, old_val;
  logic                      mem_we;

  assign acc_busy = (acc_st != wds_pkg::WDS_ACC_IDLE);
  assign trial    = `WDS_SUM_W'(den) << bit_k;

  // peak when peak_average_select was high at the close, mean when low; max retain keeps the larger
  // the stored value is read here, not in an assign, so that a storage write wakes it
  always_comb begin
    old_val = mem_rd(cl_x[0], index_of(cl_x));
    wval = cl_pas ? cl_peak : quot;
    if (max_on && old_val > wval) begin
      wval = old_val;
    end
  end

  // A is frozen in hold and difference modes; B always updates
  assign mem_we = (acc_st == wds_pkg::WDS_ACC_MERGE) && (32'(index_of(cl_x)) < DEPTH)
                  && (cl_x[0] || !(hold_a || diff_on));

  always_comb begin
    next_acc_st      = acc_st;
    next_sum         = sum;
    next_cnt         = cnt;
    next_peak        = peak;
    next_cur_x       = cur_x;
    next_cur_valid   = cur_valid;
    next_num         = num;
    next_den         = den;
    next_cl_peak     = cl_peak;
    next_cl_x        = cl_x;
    next_cl_pas      = cl_pas;
    next_quot        = quot;
    next_bit_k       = bit_k;
    next_start       = 1'b0;
    next_last_sample = last_sample;
    if (conversion_done_pulse) begin
      next_last_sample = sample;
      if (cur_valid && acq_x != cur_x && !acc_busy) begin
        // position left: close it and restart with this sample
        next_start   = 1'b1;
        next_num     = sum;
        next_den     = cnt;
        next_cl_peak = peak;
        next_cl_x    = cur_x;
        next_cl_pas  = pas_s;
        next_quot    = 8'h00;
        next_bit_k   = 3'h7;
        next_acc_st  = wds_pkg::WDS_ACC_DIV;
        next_sum     = `WDS_SUM_W'(sample);
        next_cnt     = `WDS_CNT_W'(1);
        next_peak    = sample;
        next_cur_x   = acq_x;
      end else if (!cur_valid || acq_x != cur_x) begin
        // first sample, or position moved while still closing: restart
        next_cur_valid = 1'b1;
        next_sum       = `WDS_SUM_W'(sample);
        next_cnt       = `WDS_CNT_W'(1);
        next_peak      = sample;
        next_cur_x     = acq_x;
      end else begin
        next_sum  = sum + `WDS_SUM_W'(sample);
        // the count saturates at all ones, so in an endless dwell only the sum can wrap
        next_cnt  = (&cnt) ? cnt : cnt + `WDS_CNT_W'(1);
        next_peak = (sample > peak) ? sample : peak;
      end
    end
    unique case (acc_st)
      wds_pkg::WDS_ACC_IDLE: ;
      wds_pkg::WDS_ACC_DIV: begin
        // restoring divide, one quotient bit per core clock
        if (num >= trial) begin
          next_num         = num - trial;
          next_quot[bit_k] = 1'b1;
        end
        next_bit_k = bit_k - 3'h1;
        if (bit_k == 3'h0) begin
          next_acc_st = wds_pkg::WDS_ACC_MERGE;
        end
      end
      wds_pkg::WDS_ACC_MERGE: next_acc_st = wds_pkg::WDS_ACC_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      acc_st                <= wds_pkg::WDS_ACC_IDLE;
      sum                   <= '0;
      cnt                   <= '0;
      peak                  <= 8'h00;
      cur_x                 <= 10'h000;
      cur_valid             <= 1'b0;
      num                   <= '0;
      den                   <= '0;
      cl_peak               <= 8'h00;
      cl_x                  <= 10'h000;
      cl_pas                <= 1'b0;
      quot                  <= 8'h00;
      bit_k                 <= 3'h0;
      x_change_divide_start <= 1'b0;
      last_sample           <= 8'h00;
    end else begin
      acc_st                <= next_acc_st;
      sum                   <= next_sum;
      cnt                   <= next_cnt;
      peak                  <= next_peak;
      cur_x                 <= next_cur_x;
      cur_valid             <= next_cur_valid;
      num                   <= next_num;
      den                   <= next_den;
      cl_peak               <= next_cl_peak;
      cl_x                  <= next_cl_x;
      cl_pas                <= next_cl_pas;
      quot                  <= next_quot;
      bit_k                 <= next_bit_k;
      x_change_divide_start <= next_start;
      last_sample           <= next_last_sample;
    end
  end

  // storage write port
  always_ff @(posedge core_clk) begin
    if (mem_we) begin
      mem[cl_x[0]][index_of(cl_x)] <= wval;
    end
  end

  // ---------------------------------------------------------------
  // display sweep
  // ---------------------------------------------------------------
  wds_pkg::wds_dsp_e dsp_st, next_dsp_st;
  logic [9:0]  dsp_pos, next_dsp_pos;
  logic [7:0]  pause_cnt, next_pause_cnt;
  logic        trace_b, next_trace_b;
  logic [9:0]  next_disp_x;
  logic [7:0]  next_disp_y;
  logic        next_disp_blank, next_cursor_sel, next_marker;
  logic        two_traces;
  logic [9:0]  diff_val;

  assign two_traces = show_a && show_b && hold_a && !diff_on;

  always_comb begin
    // b - a + k, read in the process so storage writes wake it; off-screen results blank
    diff_val        = {2'b00, mem_rd(1'b1, index_of(dsp_pos))} - {2'b00, mem_rd(1'b0, index_of(dsp_pos))}
                      + {2'b00, diff_k};
    next_dsp_st     = dsp_st;
    next_dsp_pos    = dsp_pos;
    next_pause_cnt  = pause_cnt;
    next_trace_b    = trace_b;
    next_disp_x     = dsp_pos;
    next_disp_y     = 8'h00;
    next_disp_blank = 1'b0;
    next_cursor_sel = (dsp_st == wds_pkg::WDS_DSP_CURSOR);
    next_marker     = 1'b0;
    unique case (dsp_st)
      wds_pkg::WDS_DSP_DRAW: begin
        if (diff_on) begin
          next_disp_y     = diff_val[7:0];
          next_disp_blank = diff_val[9] | diff_val[8];
        end else if (show_a && show_b && !hold_a) begin
          next_disp_y = mem_rd(dsp_pos[0], index_of(dsp_pos));
        end else if (two_traces) begin
          next_disp_y = mem_rd(trace_b, index_of(dsp_pos));
        end else if (show_a || show_b) begin
          next_disp_y = mem_rd(show_b, index_of(dsp_pos));
        end else begin
          next_disp_blank = 1'b1;
        end
      end
      wds_pkg::WDS_DSP_CURSOR: next_disp_y = cursor_level;
    endcase
    if (tick) begin
      if (dsp_st == wds_pkg::WDS_DSP_CURSOR && dsp_pos == acq_x
          && 32'(pause_cnt) < MARKER_TICKS) begin
        next_pause_cnt = pause_cnt + 8'h01;
      end else begin
        next_pause_cnt = 8'h00;
        if (32'(dsp_pos) == `WDS_DISP_POSITIONS - 1) begin
          next_dsp_pos = 10'h000;
          if (dsp_st == wds_pkg::WDS_DSP_DRAW) begin
            next_dsp_st = wds_pkg::WDS_DSP_CURSOR;
          end else begin
            next_dsp_st  = wds_pkg::WDS_DSP_DRAW;
            next_trace_b = two_traces ? ~trace_b : 1'b0;
          end
        end else begin
          next_dsp_pos = dsp_pos + 10'h001;
        end
      end
    end
    next_marker = (pause_cnt != 8'h00);
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      dsp_st              <= wds_pkg::WDS_DSP_DRAW;
      dsp_pos             <= 10'h000;
      pause_cnt           <= 8'h00;
      trace_b             <= 1'b0;
      disp_x              <= 10'h000;
      disp_y              <= 8'h00;
      disp_blank          <= 1'b1;
      cursor_cycle_select <= 1'b0;
      disp_trace_b        <= 1'b0;
      marker_pause        <= 1'b0;
    end else begin
      dsp_st              <= next_dsp_st;
      dsp_pos             <= next_dsp_pos;
      pause_cnt           <= next_pause_cnt;
      trace_b             <= next_trace_b;
      disp_x              <= next_disp_x;
      disp_y              <= next_disp_y;
      disp_blank          <= next_disp_blank;
      cursor_cycle_select <= next_cursor_sel;
      disp_trace_b        <= trace_b;
      marker_pause        <= next_marker;
    end
  end

endmodule : wds_top

`default_nettype wire

// ### inc/wds_map.svh
`ifndef WDS_MAP_SVH
`define WDS_MAP_SVH

// ---------------------------------------------------------------
// instrument bus addresses
// ---------------------------------------------------------------
`define WDS_ADDR_WR_A       8'h7a
`define WDS_ADDR_WR_B       8'h7b
`define WDS_ADDR_RD_A       8'hfa
`define WDS_ADDR_RD_B       8'hfb

// ---------------------------------------------------------------
// fields of storage_write_port_b
// ---------------------------------------------------------------
`define WDS_SUB_LSB         0
`define WDS_SUB_MSB         2
`define WDS_SECT_BIT        3

// ---------------------------------------------------------------
// horizontal subaddresses behind storage_write_port_a
// ---------------------------------------------------------------
`define WDS_SUB_MODE        3'h0
`define WDS_SUB_CURSOR      3'h1
`define WDS_SUB_RD_LO       3'h2
`define WDS_SUB_RD_HI       3'h3

// ---------------------------------------------------------------
// mode field positions and reset value
// ---------------------------------------------------------------
`define WDS_MODE_HOLD_A_BIT 0
`define WDS_MODE_MAX_BIT    1
`define WDS_MODE_DIFF_BIT   2
`define WDS_MODE_SHOW_A_BIT 3
`define WDS_MODE_SHOW_B_BIT 4
`define WDS_MODE_RESET      5'h18
`define WDS_RD_TBL_BIT      1

// ---------------------------------------------------------------
// sizes and timing counts
// ---------------------------------------------------------------
`define WDS_TABLE_DEPTH     500
`define WDS_DISP_POSITIONS  1000
`define WDS_SAR_STEPS       8
`define WDS_SUM_W           25
`define WDS_CNT_W           17
`define WDS_MARKER_TICKS    4

`endif

// ### inc/wds_pkg.sv
`default_nettype none

package wds_pkg;

  // instrument bus request as seen on the pins
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } wds_bus_req_s;

  // closing of one horizontal position
  typedef enum logic [2:0] {
    WDS_ACC_IDLE  = 3'b001,
    WDS_ACC_DIV   = 3'b010,
    WDS_ACC_MERGE = 3'b100
  } wds_acc_e;

  // display sweep phase
  typedef enum logic [1:0] {
    WDS_DSP_DRAW   = 2'b01,
    WDS_DSP_CURSOR = 2'b10
  } wds_dsp_e;

endpackage : wds_pkg

`default_nettype wire

// ### verification/wds_proc_model.sv
`default_nettype none

// far side: phase-two timing pin and the vertical comparator
module wds_proc_model (
  // comparator
  input  wire logic [7:0] vert_dac_code,
  input  wire logic [7:0] level,
  output logic            vert_comp_high,
  // timing
  output logic            processor_phase_two_clock
);
  timeunit 1ns;
  timeprecision 1ns;
  // input sits half a code above level, so a clean conversion lands on level
  assign vert_comp_high = level >= vert_dac_code;
  // free running 1 MHz timing
  initial processor_phase_two_clock = 1'b0;
  always #500 processor_phase_two_clock = ~processor_phase_two_clock;
endmodule : wds_proc_model

`default_nettype wire

// ### verification/wds_top_monitor.sv
`default_nettype none

// pin level checks of the storage block
module wds_top_monitor (
  // clock and reset
  input wire logic                  core_clk,
  input wire logic                  reset,
  // bus and conversion
  input wire wds_pkg::wds_bus_req_s bus_req,
  input wire logic [7:0]            bus_rdata,
  input wire logic [7:0]            vert_dac_code,
  input wire logic                  conversion_done_pulse,
  input wire logic                  x_change_divide_start,
  // display
  input wire logic [9:0]            disp_x
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (reset);
  // read strobe to an address that nobody answers
  sequence s_other_read;
    $rose(bus_req.rd) && !(bus_req.addr inside {8'hfa, 8'hfb});
  endsequence
  done_gap_a: assert property (conversion_done_pulse |=> !conversion_done_pulse [*8])
    else $error("done pulses too close");
  div_gap_a: assert property (x_change_divide_start |=> !x_change_divide_start [*8])
    else $error("divide start repeated");
  div_cause_a: assert property (x_change_divide_start |-> $past(conversion_done_pulse))
    else $error("divide start without conversion end");
  div_apart_a: assert property (conversion_done_pulse |-> !x_change_divide_start)
    else $error("divide start with conversion end");
  dac_restart_a: assert property (conversion_done_pulse |-> ##[0:140] vert_dac_code == 8'h80)
    else $error("trial code not restarted");
  dac_steady_a: assert property ($changed(vert_dac_code) |=> $stable(vert_dac_code) [*8])
    else $error("trial code moved between ticks");
  // the answer is registered on the third edge after the strobe rises
  rdata_hold_a: assert property ($changed(bus_rdata) |-> $past(bus_req.rd, 3))
    else $error("read data moved without a read");
  other_zero_a: assert property (s_other_read |-> ##5 bus_rdata == 8'h00)
    else $error("unmapped read not zero");
  // the display position only steps forward by one or wraps to the start
  disp_step_a: assert property ($changed(disp_x) |-> disp_x == $past(disp_x) + 10'h001 || disp_x == 10'h000)
    else $error("display position jumped");
endmodule : wds_top_monitor

bind wds_top wds_top_monitor mon_u (.core_clk, .reset, .bus_req, .bus_rdata, .vert_dac_code,
  .conversion_done_pulse, .x_change_divide_start, .disp_x);

`default_nettype wire

// ### verification/wds_top_test.sv
`default_nettype none

module wds_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic                  core_clk = 1'b0;
  logic                  reset = 1'b1;
  logic [9:0]            sx = 10'h000;
  logic [7:0]            level = 8'h5a;
  logic [7:0]            rdv, dac, rdata;
  logic                  p2, comp, xdiv, blank;
  logic                  pas = 1'b1;
  wds_pkg::wds_bus_req_s req = '0;
  int                    n_errors = 0;
  int                    total_checks = 0;
  // 125 MHz core clock
  always #4 core_clk = ~core_clk;
  wds_proc_model pm_u (.vert_dac_code(dac), .level(level), .vert_comp_high(comp),
    .processor_phase_two_clock(p2));
  // peak stays selected until the mean scenario lowers pas
  wds_top dut_u (.core_clk, .reset, .bus_req(req), .bus_rdata(rdata), .processor_phase_two_clock(p2),
    .vert_comp_high(comp), .peak_average_select(pas), .sweep_x_code(sx), .vert_dac_code(dac),
    .conversion_done_pulse(), .x_change_divide_start(xdiv), .disp_x(), .disp_y(), .disp_blank(blank),
    .cursor_cycle_select(), .disp_trace_b(), .marker_pause());
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one bus cycle; no ack exists, so the strobe is held past the answer
  task automatic op(input logic w, input logic [7:0] a, input logic [7:0] d);
    req <= '{w, !w, a, d};
    repeat (6) @(negedge core_clk);
    rdv = rdata;
    req.wr <= 1'b0;
    req.rd <= 1'b0;
    repeat (4) @(negedge core_clk);
  endtask : op
  task automatic tbl(input logic [7:0] i, input logic [7:0] t, input logic [7:0] exp);
    op(1'b1, 8'h7b, 8'h02);
    op(1'b1, 8'h7a, i);
    op(1'b1, 8'h7b, 8'h03);
    op(1'b1, 8'h7a, t);
    op(1'b1, 8'h7b, 8'h08);
    op(1'b0, 8'hfa, 8'h00);
    chk(rdv, exp);
  endtask : tbl
  // move the sweep and wait for the old spot to close
  task automatic enter(input logic [9:0] x);
    sx <= x;
    for (int k = 0; k < 3000 && xdiv !== 1'b1; k++) @(negedge core_clk);
    chk({7'h00, xdiv}, 8'h01);
  endtask : enter
  // then dwell two more conversions on the new spot
  task automatic visit(input logic [9:0] x);
    enter(x);
    repeat (2400) @(negedge core_clk);
  endtask : visit
  task automatic t_modes;
    logic [7:0] m[5] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10};
    op(1'b1, 8'h7b, 8'h00);
    op(1'b0, 8'hfb, 8'h00);
    chk({3'h0, rdv[6:2]}, 8'h18);
    foreach (m[i]) begin
      op(1'b1, 8'h7a, m[i]);
      // with no table shown and no difference, every point of the draw sweep is blanked
      if (m[i][2] == 1'b0) begin
        chk({7'h00, blank}, {7'h00, m[i][4:3] == 2'b00});
      end
      op(1'b0, 8'hfb, 8'h00);
      chk({3'h0, rdv[6:2]}, m[i]);
    end
    op(1'b1, 8'h7b, 8'h05);
    op(1'b1, 8'h7a, 8'h18);
    op(1'b1, 8'h7b, 8'h00);
    op(1'b0, 8'hfb, 8'h00);
    chk({3'h0, rdv[6:2]}, 8'h10);
    op(1'b0, 8'h55, 8'h00);
    chk(rdv, 8'h00);
    op(1'b1, 8'h7a, 8'h18);
    $display("modes test done");
  endtask : t_modes
  task automatic t_store;
    // the first conversion only fixes the start spot, so no close can happen before it
    repeat (1100) @(negedge core_clk);
    visit(10'h006);
    visit(10'h007);
    op(1'b1, 8'h7b, 8'h08);
    op(1'b0, 8'hfb, 8'h00);
    chk(rdv, 8'h5a);
    tbl(8'h03, 8'h00, 8'h5a);
    op(1'b1, 8'h7b, 8'h00);
    op(1'b1, 8'h7a, 8'h19);
    level <= 8'h30;
    visit(10'h009);
    visit(10'h007);
    visit(10'h006);
    visit(10'h007);
    tbl(8'h03, 8'h02, 8'h30);
    tbl(8'h03, 8'h00, 8'h5a);
    // mean of one 0x30 and two 0x10 samples is 0x1a, where the peak would be 0x30
    pas <= 1'b0;
    enter(10'h00b);
    level <= 8'h10;
    repeat (2400) @(negedge core_clk);
    visit(10'h00d);
    tbl(8'h05, 8'h02, 8'h1a);
    $display("store test done");
  endtask : t_store
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop
  // main sequence
  initial begin
    repeat (4) @(negedge core_clk);
    reset <= 1'b0;
    @(negedge core_clk);
    t_modes();
    t_store();
    report_and_stop();
  end
  // watchdog, about twice the expected run
  initial begin
    repeat (60000) @(posedge core_clk);
    n_errors++;
    report_and_stop();
  end
endmodule : wds_top_test

`default_nettype wire
